// file: logic/interval_clock_pkg.sv
package interval_clock_pkg;
	// ======================================================================
	// Processor register numbers
	localparam logic [7:0] REG_CONTROL_STATUS = 8'h18;
	localparam logic [7:0] REG_NEXT_INTERVAL = 8'h19;
	localparam logic [7:0] REG_INTERVAL_COUNTER = 8'h1a;
	// ======================================================================
	// Control/status bit positions
	localparam int BIT_RUN = 0;
	localparam int BIT_TRANSFER = 4;
	localparam int BIT_SINGLE_STEP = 5;
	localparam int BIT_INT_ENABLE = 6;
	localparam int BIT_INT_FLAG = 7;
	localparam int BIT_MISSED = 31;
	// ======================================================================
	// Reset values and timing
	localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;
	localparam logic [31:0] NEXT_RESET = 32'h0000_0000;
	localparam int CLOCK_HZ = 40000000;
	localparam int TICK_NS = 1000;
	localparam int CLOCK_PERIOD_NS = 25;
	localparam int TICK_CYCLES = TICK_NS / CLOCK_PERIOD_NS;
	localparam int SUBSET_PERIOD_MS = 10;
	localparam int SUBSET_TICKS = SUBSET_PERIOD_MS * 1000;
endpackage

// file: logic/interval_clock_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Read-only counter counts microsecond ticks while running
// - Overflow reloads counter, interrupts if enabled
// - Next-interval write-only, kept after each reload
// - Next-interval writable at any time
// - Run clear freezes counter, ticks ignored
// - Bootstrap reset clears run bit
// - Transfer bit write-only, loads counter from next
// - Single-step while stopped adds exactly one
// - Overflow interrupt only while enable set
// - Enable with flag already set requests interrupt
// - Every overflow sets interrupt flag
// - Writing flag clear re-arms tick interrupt
// - Overflow with flag set sets sticky missed
// - Subset mode interrupts every 10 ms when running and enabled
// - One write sets enable, transfer, run together
// - Exactly three registers visible to software
// - Access only via privileged register operations
module interval_clock_timer
	import interval_clock_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter bit SUBSET = 1'b0,
	parameter int PRESCALE = TICK_CYCLES,
	parameter int SUBSET_COUNT = SUBSET_TICKS
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic privileged_register_write,
	input wire logic privileged_register_read,
	input wire logic [7:0] reg_number,
	input wire logic [31:0] write_data,
	output logic [31:0] read_data,
	output logic read_valid,
	output logic interrupt_request
);

	// ======================================================================
	// Prescaler
	logic [15:0] prescale_count;
	logic [15:0] next_prescale_count;
	logic tick;
	logic next_tick;

	always_comb begin
		next_prescale_count = prescale_count + 16'h0001;
		next_tick = 1'b0;
		if (prescale_count == 16'(PRESCALE - 1)) begin
			next_prescale_count = 16'h0000;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			prescale_count <= 16'h0000;
			tick <= 1'b0;
		end else begin
			prescale_count <= next_prescale_count;
			tick <= next_tick;
		end
	end

	// ======================================================================
	// Register access decode
	logic wr_status;
	logic wr_next;
	logic rd_any;
	assign wr_status = privileged_register_write && (reg_number == REG_CONTROL_STATUS);
	assign wr_next = privileged_register_write && (reg_number == REG_NEXT_INTERVAL);
	assign rd_any = privileged_register_read;

	// ======================================================================
	// Counter and control state
	logic [WIDTH-1:0] interval_counter;
	logic [WIDTH-1:0] next_interval_value;
	logic run;
	logic int_enable;
	logic int_flag;
	logic missed;
	logic [15:0] subset_count;
	logic [WIDTH-1:0] next_interval_counter;
	logic [WIDTH-1:0] next_next_interval_value;
	logic next_run;
	logic next_int_enable;
	logic next_int_flag;
	logic next_missed;
	logic [15:0] next_subset_count;
	logic overflow;
	logic step;
	logic [WIDTH:0] sum;

	always_comb begin
		next_interval_counter = interval_counter;
		next_next_interval_value = next_interval_value;
		next_run = run;
		next_int_enable = int_enable;
		next_int_flag = int_flag;
		next_missed = missed;
		next_subset_count = subset_count;
		overflow = 1'b0;
		step = 1'b0;
		sum = {1'b0, interval_counter} + {{WIDTH{1'b0}}, 1'b1};
		if (wr_next) begin
			next_next_interval_value = write_data[WIDTH-1:0];
		end
		if (SUBSET) begin
			if (run && tick) begin
				if (subset_count == 16'(SUBSET_COUNT - 1)) begin
					next_subset_count = 16'h0000;
					overflow = 1'b1;
				end else begin
					next_subset_count = subset_count + 16'h0001;
				end
			end
		end else begin
			step = (run && tick)
				|| (!run && wr_status && write_data[BIT_SINGLE_STEP]);
			if (step) begin
				if (sum[WIDTH]) begin
					overflow = 1'b1;
					next_interval_counter = next_interval_value;
				end else begin
					next_interval_counter = sum[WIDTH-1:0];
				end
			end
		end
		if (wr_status) begin
			next_run = write_data[BIT_RUN];
			next_int_enable = write_data[BIT_INT_ENABLE];
			if (write_data[BIT_INT_FLAG]) begin
				next_int_flag = 1'b0;
			end
			if (write_data[BIT_MISSED]) begin
				next_missed = 1'b0;
			end
			if (write_data[BIT_TRANSFER] && !SUBSET) begin
				next_interval_counter = next_interval_value;
			end
		end
		if (overflow) begin
			next_int_flag = 1'b1;
			if (int_flag) begin
				next_missed = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			interval_counter <= COUNTER_RESET;
			next_interval_value <= NEXT_RESET;
			run <= 1'b0;
			int_enable <= 1'b0;
			int_flag <= 1'b0;
			missed <= 1'b0;
			subset_count <= 16'h0000;
		end else begin
			interval_counter <= next_interval_counter;
			next_interval_value <= next_next_interval_value;
			run <= next_run;
			int_enable <= next_int_enable;
			int_flag <= next_int_flag;
			missed <= next_missed;
			subset_count <= next_subset_count;
		end
	end

	// ======================================================================
	// Interrupt request and read port
	logic [31:0] status_word;
	logic [31:0] next_read_data;
	logic next_read_valid;
	logic next_interrupt_request;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[BIT_RUN] = run;
		status_word[BIT_INT_ENABLE] = int_enable;
		status_word[BIT_INT_FLAG] = int_flag;
		status_word[BIT_MISSED] = missed;
		next_read_valid = rd_any;
		next_read_data = 32'h0000_0000;
		if (rd_any) begin
			unique case (reg_number)
				REG_CONTROL_STATUS: next_read_data = status_word;
				REG_INTERVAL_COUNTER: next_read_data = SUBSET ? 32'h0000_0000 : 32'(interval_counter);
				default: next_read_data = 32'h0000_0000;
			endcase
		end
		next_interrupt_request = next_int_enable && next_int_flag;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			read_data <= 32'h0000_0000;
			read_valid <= 1'b0;
			interrupt_request <= 1'b0;
		end else begin
			read_data <= next_read_data;
			read_valid <= next_read_valid;
			interrupt_request <= next_interrupt_request;
		end
	end

endmodule
`default_nettype wire

// file: testbench/interval_clock_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module interval_clock_monitor
	import interval_clock_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic privileged_register_write,
	input wire logic privileged_register_read,
	input wire logic [7:0] reg_number,
	input wire logic [31:0] write_data,
	input wire logic [31:0] read_data,
	input wire logic read_valid,
	input wire logic interrupt_request
);
	// ==========
	// Checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	wire logic rd = privileged_register_read;
	wire logic wr = privileged_register_write;
	wire logic sel = reg_number == REG_CONTROL_STATUS;
	chk_read_answer: assert property (rd |=> read_valid)
		else $error("no answer");
	chk_no_stray: assert property (!rd |=> !read_valid && read_data == 0)
		else $error("stray answer");
	chk_next_hidden: assert property (rd && reg_number == REG_NEXT_INTERVAL |=> read_data == 0)
		else $error("next readable");
	chk_status_wo_bits: assert property (rd && sel |=> read_data[5:4] == 2'b00)
		else $error("wo bits seen");
	chk_unmapped_zero: assert property (rd && reg_number < 8'h18 |=> read_data == 0)
		else $error("unmapped data");
	chk_irq_masked: assert property (wr && sel && !write_data[6] ##1 !wr |-> ##1 !interrupt_request)
		else $error("irq while masked");
	chk_irq_shown: assert property (rd && sel && interrupt_request && !wr && $past(!wr)
		|=> read_data[7:6] == 2'b11)
		else $error("irq without cause");
	chk_reset_clean: assert property ($rose(rst_b) |-> !interrupt_request && !read_valid)
		else $error("reset not clean");
endmodule
bind interval_clock_timer interval_clock_monitor interval_clock_monitor_inst (.sys_clk(sys_clk),
	.rst_b(rst_b), .privileged_register_write(privileged_register_write),
	.privileged_register_read(privileged_register_read), .reg_number(reg_number),
	.write_data(write_data), .read_data(read_data), .read_valid(read_valid),
	.interrupt_request(interrupt_request));
`default_nettype wire

// file: testbench/interval_clock_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module interval_clock_timer_tb_top
	import interval_clock_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic privileged_register_write = 1'b0;
	logic privileged_register_read = 1'b0;
	logic [7:0] reg_number = 8'h00;
	logic [31:0] write_data = 32'h0;
	logic [31:0] read_data;
	logic read_valid;
	logic interrupt_request;
	logic [31:0] sub_read_data;
	logic sub_read_valid;
	logic sub_irq;
	logic [31:0] v;
	int fails = 0;
	int n_compared = 0;
	interval_clock_timer #(.PRESCALE(4)) interval_clock_timer_inst (.sys_clk(sys_clk),
		.rst_b(rst_b), .privileged_register_write(privileged_register_write),
		.privileged_register_read(privileged_register_read), .reg_number(reg_number),
		.write_data(write_data), .read_data(read_data), .read_valid(read_valid),
		.interrupt_request(interrupt_request));
	interval_clock_timer #(.SUBSET(1'b1), .PRESCALE(4), .SUBSET_COUNT(5))
		interval_clock_timer_subset_inst (.sys_clk(sys_clk),
		.rst_b(rst_b), .privileged_register_write(privileged_register_write),
		.privileged_register_read(privileged_register_read), .reg_number(reg_number),
		.write_data(write_data), .read_data(sub_read_data), .read_valid(sub_read_valid),
		.interrupt_request(sub_irq));
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	// ==========
	// Access tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] r, input logic [31:0] d);
		@(posedge sys_clk);
		privileged_register_write <= 1'b1;
		reg_number <= r;
		write_data <= d;
		@(posedge sys_clk);
		privileged_register_write <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] r, input logic [31:0] e);
		@(posedge sys_clk);
		privileged_register_read <= 1'b1;
		reg_number <= r;
		@(posedge sys_clk);
		privileged_register_read <= 1'b0;
		#1;
		v = read_valid === 1'b1 ? read_data : 32'hxxxxxxxx;
		chk("reg", e, v);
	endtask
	task automatic rd_only(input logic [7:0] r);
		@(posedge sys_clk);
		privileged_register_read <= 1'b1;
		reg_number <= r;
		@(posedge sys_clk);
		privileged_register_read <= 1'b0;
		#1;
		v = read_valid === 1'b1 ? read_data : 32'hxxxxxxxx;
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge sys_clk);
		fails++;
		tally_and_finish;
	end
	// ==========
	// Tests
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		rc(REG_INTERVAL_COUNTER, 32'h0);
		rc(REG_CONTROL_STATUS, 32'h0);
		rc(REG_NEXT_INTERVAL, 32'h0);
		rc(8'h00, 32'h0);
		$display("test 1 done");
		wr(REG_NEXT_INTERVAL, 32'hffff_fffe);
		wr(REG_CONTROL_STATUS, 32'h10);
		rc(REG_INTERVAL_COUNTER, 32'hffff_fffe);
		wr(REG_CONTROL_STATUS, 32'h20);
		rc(REG_INTERVAL_COUNTER, 32'hffff_ffff);
		wr(REG_CONTROL_STATUS, 32'h20);
		rc(REG_INTERVAL_COUNTER, 32'hffff_fffe);
		rc(REG_CONTROL_STATUS, 32'h80);
		chk("irq", 32'h0, {31'h0, interrupt_request});
		wr(REG_CONTROL_STATUS, 32'h20);
		wr(REG_CONTROL_STATUS, 32'h20);
		rc(REG_CONTROL_STATUS, 32'h8000_0080);
		wr(REG_CONTROL_STATUS, 32'h40);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("irq", 32'h1, {31'h0, interrupt_request});
		wr(REG_CONTROL_STATUS, 32'h8000_00c0);
		rc(REG_CONTROL_STATUS, 32'h40);
		wr(REG_INTERVAL_COUNTER, 32'h0);
		rc(REG_INTERVAL_COUNTER, 32'hffff_fffe);
		$display("test 2 done");
		wr(REG_NEXT_INTERVAL, 32'hffff_fff6);
		wr(REG_CONTROL_STATUS, 32'h51);
		for (int i = 0; i < 200 && !interrupt_request; i++) begin
			@(posedge sys_clk);
			#1;
		end
		chk("irq", 32'h1, {31'h0, interrupt_request});
		rc(REG_CONTROL_STATUS, 32'hc1);
		wr(REG_CONTROL_STATUS, 32'h80);
		rd_only(REG_INTERVAL_COUNTER);
		chk("range", 32'hffff_fff0, v & 32'hffff_fff0);
		repeat (20) @(posedge sys_clk);
		rc(REG_INTERVAL_COUNTER, v);
		$display("test 3 done");
		wr(REG_CONTROL_STATUS, 32'h41);
		#1;
		chk("subset irq", 32'h0, {31'h0, sub_irq});
		for (int i = 0; i < 40 && !sub_irq; i++) begin
			@(posedge sys_clk);
			#1;
		end
		chk("subset irq", 32'h1, {31'h0, sub_irq});
		$display("test 4 done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
